// ==== hdl/sdc_cfg.svh ====
// Constants for the sigma-delta decimation control block.
// Assumes a 32-bit Avalon-MM slave with word addresses in bytes.
`ifndef SDC_CFG_SVH
`define SDC_CFG_SVH

// ============================================================
// Register offsets (byte addresses)
`define SDC_ADDR_W        4
`define SDC_OFF_CTRL      4'h0
`define SDC_OFF_STATUS    4'h4
`define SDC_OFF_RESULT    4'h8

// ============================================================
// Control register field positions
`define SDC_C_START       0
`define SDC_C_SINGLE      1
`define SDC_C_GROUP       2
`define SDC_C_UNI         3
`define SDC_C_DF          4
`define SDC_C_LOW_WORD_ACCESS_ALIAS      5
`define SDC_C_LSBTOG      6
`define SDC_C_OSR_LO      7
`define SDC_C_XOSR        9
`define SDC_C_DLY_LO      10
`define SDC_C_SRC         12
`define SDC_C_DIV_LO      13

// Status register field positions
`define SDC_S_FLAG        0
`define SDC_S_RUN         1

// ============================================================
// Reset values: ratio 256, no delay override, core clock, /1
`define SDC_RST_OSR       2'h0
`define SDC_RST_DLY       2'h0
`define SDC_RST_DIV       2'h0

// Filter and conversion counts
`define SDC_ACC_W         32
`define SDC_OSR_LOG_W     4
`define SDC_CNT_SAT       3'h4
`define SDC_DIV_W         3

`endif

// ==== hdl/sdc_pkg.sv ====
// Types for the sigma-delta decimation control block.
// Assumes sdc_cfg.svh supplies the numeric constants.
package sdc_pkg;

  // ==========================================================
  // Channel activity
  typedef enum logic {SDC_IDLE, SDC_RUN} sdc_state_t;

  // Data format of the result view
  typedef enum logic [1:0] {SDC_FMT_OFFSET, SDC_FMT_TWOS, SDC_FMT_UNI}
    sdc_fmt_t;

endpackage

// ==== hdl/sdc_decim_ctrl.sv ====
// One converter channel back end: sinc3 decimator, result register with
// word views and formats, result-ready flag, single/continuous control.
// Assumes a 1-bit modulator stream and optional external fM tick on pins,
// and neighbouring channels wired through the group ports.
//
// Local design decisions: the Avalon-MM interface to the registers and the address map.
`include "sdc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module sdc_decim_ctrl
  import sdc_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   sys_rst,
  input  wire logic                   clk_en,
  // Avalon-MM slave
  input  wire logic [`SDC_ADDR_W-1:0] avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [3:0]             avs_byteenable,
  input  wire logic [31:0]            avs_writedata,
  output logic      [31:0]            avs_readdata,
  output logic                        avs_waitrequest,
  // Modulator side pins
  input  wire logic                   mod_bit,
  input  wire logic                   ext_fm_tick,
  // Group chaining with neighbouring channels
  input  wire logic                   prev_group_with_next,
  input  wire logic                   master_start_in,
  output logic                        group_with_next_out,
  output logic                        start_conversion_out,
  // Status pins
  output logic                        result_ready_flag,
  output logic                        channel_powered_down
);

  // ==========================================================
  // Functions
  // log2 of the ratio: 256,128,64,32 then 512,1024 when extended
  function automatic logic [`SDC_OSR_LOG_W-1:0] osr_log(
    input logic [1:0] sel,
    input logic       ext
  );
    logic [`SDC_OSR_LOG_W-1:0] r;
    r = 4'h8 - {2'b00, sel};
    if (ext)
    begin
      r = sel[0] ? 4'ha : 4'h9;
    end
    return r;
  endfunction

  // Sign-extension-free modulo add used by all filter stages
  function automatic logic [`SDC_ACC_W-1:0] acc_add(
    input logic [`SDC_ACC_W-1:0] a,
    input logic [`SDC_ACC_W-1:0] b
  );
    return a + b;
  endfunction

  // ==========================================================
  // Pin synchronisers; only stage two and three are read
  logic [1:0] bit_sync_q;
  logic [2:0] tick_sync_q;

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      bit_sync_q  <= 2'b00;
      tick_sync_q <= 3'b000;
    end
    else if (clk_en)
    begin
      bit_sync_q  <= {bit_sync_q[0], mod_bit};
      tick_sync_q <= {tick_sync_q[1:0], ext_fm_tick};
    end
  end

  // ==========================================================
  // Control register state
  logic       start_q;
  logic       single_q;
  logic       group_q;
  logic       uni_q;
  logic       df_q;
  logic       low_word_access_alias_q;
  logic       lsbtog_q;
  logic [1:0] osr_q;
  logic       xosr_q;
  logic [1:0] dly_q;
  logic       src_q;
  logic [1:0] div_q;
  logic       flag_q;
  logic       rd_done_q;
  logic       master_q;
  sdc_state_t state_q;

  // ==========================================================
  // Bus decode; reads take one wait cycle so data comes from flops
  wire        sel_ctrl   = avs_address == `SDC_OFF_CTRL;
  wire        sel_status = avs_address == `SDC_OFF_STATUS;
  wire        sel_result = avs_address == `SDC_OFF_RESULT;
  wire        wr_ctrl    = avs_write & sel_ctrl & avs_byteenable[0];
  wire        wr_ctrl_hi = avs_write & sel_ctrl & avs_byteenable[1];
  wire        wr_status  = avs_write & sel_status & avs_byteenable[0];
  wire        rd_accept  = avs_read & rd_done_q;
  wire        rd_result  = rd_accept & sel_result;
  assign avs_waitrequest = avs_read & ~rd_done_q;

  // ==========================================================
  // Mode and grouping
  wire grouped   = group_q | prev_group_with_next;
  wire is_master = ~group_q & prev_group_with_next;
  wire follower  = group_q;
  wire master_rise = master_start_in & ~master_q;
  wire master_fall = ~master_start_in & master_q;
  assign group_with_next_out  = group_q;
  assign start_conversion_out = start_q;

  // ==========================================================
  // Modulator clock: source then power-of-two divider
  logic [`SDC_DIV_W-1:0] div_cnt_q;
  wire src_tick  = src_q ? (tick_sync_q[1] & ~tick_sync_q[2]) : 1'b1;
  wire [`SDC_DIV_W-1:0] div_top = `SDC_DIV_W'((1 << div_q) - 1);
  wire fm_tick   = src_tick & (div_cnt_q == div_top);
  wire running   = state_q == SDC_RUN;

  // ==========================================================
  // Sinc3: integrators at fM, differentiators at decimation
  logic [`SDC_ACC_W-1:0] i1_q;
  logic [`SDC_ACC_W-1:0] i2_q;
  logic [`SDC_ACC_W-1:0] i3_q;
  logic [`SDC_ACC_W-1:0] d1_q;
  logic [`SDC_ACC_W-1:0] d2_q;
  logic [`SDC_ACC_W-1:0] d3_q;
  logic [10:0]           phase_q;
  logic [2:0]            conv_cnt_q;
  logic [15:0]           result_hi_q;
  logic [15:0]           result_lo_q;

  wire [`SDC_OSR_LOG_W-1:0] nlog = osr_log(osr_q, xosr_q);
  wire [4:0]  out_bits = 5'(3 * nlog);
  wire [10:0] phase_top = 11'((1 << nlog) - 1);
  wire        decim = running & fm_tick & (phase_q == phase_top);

  wire [`SDC_ACC_W-1:0] i1_d = acc_add(i1_q, {31'h0, bit_sync_q[1]});
  wire [`SDC_ACC_W-1:0] i2_d = acc_add(i2_q, i1_d);
  wire [`SDC_ACC_W-1:0] i3_d = acc_add(i3_q, i2_d);
  wire [`SDC_ACC_W-1:0] c1   = acc_add(i3_d, ~d1_q + 32'h1);
  wire [`SDC_ACC_W-1:0] c2   = acc_add(c1, ~d2_q + 32'h1);
  wire [`SDC_ACC_W-1:0] c3   = acc_add(c2, ~d3_q + 32'h1);

  // Full scale equals ratio cubed; clamp it to the all-ones code
  wire [`SDC_ACC_W-1:0] full  = `SDC_ACC_W'(1) << out_bits;
  wire [`SDC_ACC_W-1:0] raw   = (c3 >= full) ? full - 32'h1 : c3;
  wire [`SDC_ACC_W-1:0] half  = full >> 1;

  // ==========================================================
  // Format and 16-bit windows
  sdc_fmt_t fmt;
  assign fmt = uni_q ? SDC_FMT_UNI : (df_q ? SDC_FMT_TWOS : SDC_FMT_OFFSET);
  wire [`SDC_ACC_W-1:0] uni_v = (raw < half) ? 32'h0
                                : ((raw - half) << 1);
  wire [`SDC_ACC_W-1:0] fval  = (fmt == SDC_FMT_UNI)  ? uni_v :
                                (fmt == SDC_FMT_TWOS) ? (raw ^ half) :
                                raw;
  // Left-justify so the 15-bit output at ratio 32 gets a zero LSB
  wire [`SDC_ACC_W-1:0] fjust = fval << (6'd32 - {1'b0, out_bits});

  // ==========================================================
  // Conversion bookkeeping and notification
  wire [2:0] notify_at = 3'h4 - {1'b0, dly_q};
  wire       cnt_next_ok = (conv_cnt_q + 3'h1) >= notify_at;
  wire       notify  = decim & cnt_next_ok;
  // Start bit: software, group master and single-shot completion
  logic start_d;
  always_comb
  begin
    start_d = start_q;
    // A group master ends its own single shot like a lone channel
    if (notify & single_q & (~grouped | is_master))
      start_d = 1'b0;
    if (follower & master_rise)
      start_d = 1'b1;
    if (follower & master_fall)
      start_d = 1'b0;
    if (follower & notify & single_q)
      start_d = 1'b0;
    if (wr_ctrl)
      start_d = avs_writedata[`SDC_C_START];
  end

  // Start bit, channel state and master edge tracking
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      start_q  <= 1'b0;
      master_q <= 1'b0;
      state_q  <= SDC_IDLE;
    end
    else if (clk_en)
    begin
      start_q  <= start_d;
      master_q <= master_start_in;
      state_q  <= start_d ? SDC_RUN : SDC_IDLE;
    end
  end

  // Filter halts at once when the start bit drops
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      i1_q <= '0;
      i2_q <= '0;
      i3_q <= '0;
      d1_q <= '0;
      d2_q <= '0;
      d3_q <= '0;
      phase_q    <= 11'h0;
      div_cnt_q  <= '0;
      conv_cnt_q <= 3'h0;
    end
    else if (clk_en)
    begin
      if (!running || !start_q)
      begin
        i1_q <= '0;
        i2_q <= '0;
        i3_q <= '0;
        d1_q <= '0;
        d2_q <= '0;
        d3_q <= '0;
        phase_q    <= 11'h0;
        div_cnt_q  <= '0;
        conv_cnt_q <= 3'h0;
      end
      else if (src_tick)
      begin
        div_cnt_q <= fm_tick ? '0 : div_cnt_q + 3'h1;
        if (fm_tick)
        begin
          i1_q    <= i1_d;
          i2_q    <= i2_d;
          i3_q    <= i3_d;
          phase_q <= decim ? 11'h0 : phase_q + 11'h1;
          if (decim)
          begin
            d1_q <= i3_d;
            d2_q <= c1;
            d3_q <= c2;
            if (conv_cnt_q != `SDC_CNT_SAT)
              conv_cnt_q <= conv_cnt_q + 3'h1;
          end
        end
      end
    end
  end

  // Result register loads at every decimation step
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      result_hi_q <= 16'h0000;
      result_lo_q <= 16'h0000;
    end
    else if (clk_en && decim)
    begin
      result_hi_q <= fjust[31:16];
      result_lo_q <= fval[15:0];
    end
  end

  // ==========================================================
  // Flag: set wins over read or software clear
  wire flag_clr = rd_result
                | (wr_status & avs_writedata[`SDC_S_FLAG]);
  wire flag_set = notify & start_q;

  // View toggles on each result read while the toggle bit is set; toggle bit alone changes nothing
  wire low_word_access_alias_d = (rd_result & lsbtog_q) ? ~low_word_access_alias_q : low_word_access_alias_q;

  // Configuration fields and flag
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      single_q <= 1'b0;
      group_q  <= 1'b0;
      uni_q    <= 1'b0;
      df_q     <= 1'b0;
      low_word_access_alias_q <= 1'b0;
      lsbtog_q <= 1'b0;
      osr_q    <= `SDC_RST_OSR;
      xosr_q   <= 1'b0;
      dly_q    <= `SDC_RST_DLY;
      src_q    <= 1'b0;
      div_q    <= `SDC_RST_DIV;
      flag_q   <= 1'b0;
    end
    else if (clk_en)
    begin
      flag_q   <= flag_set | (flag_q & ~flag_clr);
      low_word_access_alias_q <= low_word_access_alias_d;
      if (wr_ctrl)
      begin
        single_q <= avs_writedata[`SDC_C_SINGLE];
        group_q  <= avs_writedata[`SDC_C_GROUP];
        uni_q    <= avs_writedata[`SDC_C_UNI];
        df_q     <= avs_writedata[`SDC_C_DF];
        low_word_access_alias_q <= avs_writedata[`SDC_C_LOW_WORD_ACCESS_ALIAS];
        lsbtog_q <= avs_writedata[`SDC_C_LSBTOG];
        osr_q[0] <= avs_writedata[`SDC_C_OSR_LO];
      end
      if (wr_ctrl_hi)
      begin
        osr_q[1] <= avs_writedata[`SDC_C_OSR_LO+1];
        xosr_q   <= avs_writedata[`SDC_C_XOSR];
        dly_q    <= avs_writedata[`SDC_C_DLY_LO+1:`SDC_C_DLY_LO];
        src_q    <= avs_writedata[`SDC_C_SRC];
        div_q    <= avs_writedata[`SDC_C_DIV_LO+1:`SDC_C_DIV_LO];
      end
    end
  end

  // ==========================================================
  // Read mux; byte read of the low view shows only 8 bits
  wire        byte_only = avs_byteenable == 4'h1;
  wire [15:0] res_view  = low_word_access_alias_q ? result_lo_q : result_hi_q;
  wire [15:0] res_out   = (low_word_access_alias_q & byte_only)
                          ? {8'h00, result_lo_q[7:0]} : res_view;
  wire [31:0] ctrl_rd   = {17'h0, div_q, src_q, dly_q, xosr_q, osr_q,
                           lsbtog_q, low_word_access_alias_q, df_q, uni_q, group_q,
                           single_q, start_q};
  wire [31:0] rd_mux    = sel_ctrl   ? ctrl_rd :
                          sel_status ? {30'h0, running, flag_q} :
                          sel_result ? {16'h0, res_out} : 32'h0000_0000;

  // Read data captured during the wait cycle
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rd_done_q    <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      rd_done_q    <= avs_read & ~rd_done_q;
      avs_readdata <= rd_mux;
    end
  end

  assign result_ready_flag    = flag_q;
  assign channel_powered_down = ~running;

endmodule

`default_nettype wire

// ==== bench/sdc_decim_ctrl_props.sv ====
// Port-level assertions for the decimation channel.
// Assumes one core clock and an async active-high reset.
`include "sdc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module sdc_decim_ctrl_props (
  input wire logic                   core_clk,
  input wire logic                   sys_rst,
  input wire logic [`SDC_ADDR_W-1:0] avs_address,
  input wire logic                   avs_read,
  input wire logic                   avs_write,
  input wire logic [31:0]            avs_writedata,
  input wire logic [31:0]            avs_readdata,
  input wire logic                   avs_waitrequest,
  input wire logic                   group_with_next_out,
  input wire logic                   start_conversion_out,
  input wire logic                   result_ready_flag,
  input wire logic                   channel_powered_down
);
  // ====================================================
  // Helpers
  logic       rd_acc;
  logic       wr_ctl;
  logic [7:0] run_cnt_q;
  logic [7:0] run_cnt_d;
  assign rd_acc = avs_read && !avs_waitrequest;
  assign wr_ctl = avs_write && avs_address == `SDC_OFF_CTRL;
  // Saturating count of cycles spent running
  assign run_cnt_d = channel_powered_down ? 8'h00 :
                     (run_cnt_q == 8'hff) ? run_cnt_q : run_cnt_q + 8'h01;
  always_ff @(posedge core_clk or posedge sys_rst)
    if (sys_rst)
      run_cnt_q <= 8'h00;
    else
      run_cnt_q <= run_cnt_d;

  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // ====================================================
  // Properties
  property p_rd_wait;
    avs_read && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait too long");
  property p_rd_first;
    $rose(avs_read) |-> avs_waitrequest;
  endproperty
  a_rd_first: assert property (p_rd_first) else $error("read not held");
  property p_wr_nowait;
    avs_write |-> !avs_waitrequest;
  endproperty
  a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
  property p_unmapped;
    rd_acc && avs_address > `SDC_OFF_RESULT |-> avs_readdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped data");
  property p_flag_clr;
    rd_acc && avs_address == `SDC_OFF_RESULT |=> !result_ready_flag;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag kept");
  property p_flag_run;
    $rose(result_ready_flag) |-> !$past(channel_powered_down);
  endproperty
  a_flag_run: assert property (p_flag_run) else $error("flag idle");
  property p_settle;
    $rose(result_ready_flag) |-> run_cnt_q >= 8'h1e;
  endproperty
  a_settle: assert property (p_settle) else $error("flag too early");
  property p_stop;
    $fell(start_conversion_out) |-> ##[0:2] channel_powered_down;
  endproperty
  a_stop: assert property (p_stop) else $error("no power down");
  property p_go;
    $rose(start_conversion_out) |-> ##[0:3] !channel_powered_down;
  endproperty
  a_go: assert property (p_go) else $error("no start");
  property p_grp;
    wr_ctl |=> group_with_next_out == $past(avs_writedata[`SDC_C_GROUP]);
  endproperty
  a_grp: assert property (p_grp) else $error("group bit lost");

  // Main scenarios reached
  c_flag: cover property ($rose(result_ready_flag));
  c_rd: cover property (rd_acc && avs_address == `SDC_OFF_RESULT);
  c_stop: cover property ($fell(start_conversion_out));
endmodule
bind sdc_decim_ctrl sdc_decim_ctrl_props u_props (.core_clk, .sys_rst,
  .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
  .avs_waitrequest, .group_with_next_out, .start_conversion_out,
  .result_ready_flag, .channel_powered_down);
`default_nettype wire

// ==== bench/sdc_mod_src.sv ====
// Modulator model: a 1-bit stream at a chosen level and a free fM tick.
// Assumes the channel synchronises both pins itself.
`timescale 1ns/1ps
`default_nettype none
module sdc_mod_src (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic [1:0] level_sel,
  output logic            mod_bit,
  output logic            ext_fm_tick
);
  // ====================================================
  // Half-rate toggle: external fM and the mid-scale pattern
  logic alt_q;
  always_ff @(posedge core_clk or posedge sys_rst)
    if (sys_rst)
      alt_q <= 1'b0;
    else
      alt_q <= ~alt_q;
  assign ext_fm_tick = alt_q;
  // 0 low full scale, 1 high full scale, 2 even density (zero)
  assign mod_bit = (level_sel == 2'h2) ? alt_q : level_sel[0];
endmodule
`default_nettype wire

// ==== bench/sdc_decim_ctrl_tb.sv ====
// Self-checking bench for the decimation channel.
// Assumes the checker is bound and fM runs at the core clock rate, except in the external-tick and /2 divider timing cases.
`include "sdc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module sdc_decim_ctrl_tb;
  // ====================================================
  // Signals
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata, rd;
  logic        avs_waitrequest, mod_bit, ext_fm_tick, group_with_next_out;
  logic        start_conversion_out, result_ready_flag, channel_powered_down;
  logic [1:0]  level_sel = 2'h1;
  logic        prev_grp = 1'b0;
  logic        master_start = 1'b0;
  int          errors = 0;
  int          num_checks = 0;
  int          n;
  time         t_last, t_prev;

  always #50 core_clk = ~core_clk;
  // Flag rise times give the conversion period
  always @(posedge result_ready_flag)
  begin
    t_prev = t_last;
    t_last = $time;
  end

  sdc_decim_ctrl DUT (.core_clk, .sys_rst, .clk_en(1'b1), .avs_address,
    .avs_read, .avs_write, .avs_byteenable, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .mod_bit, .ext_fm_tick, .prev_group_with_next(prev_grp),
    .master_start_in(master_start), .group_with_next_out, .start_conversion_out,
    .result_ready_flag, .channel_powered_down);
  sdc_mod_src u_src (.core_clk, .sys_rst, .level_sel, .mod_bit, .ext_fm_tick);

  // ====================================================
  // Common tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // One bus cycle; held until the edge that sees waitrequest low
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [15:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wait_flag(input int lim);
    n = 0;
    do
    begin
      @(negedge core_clk);
      n++;
    end
    while (result_ready_flag !== 1'b1 && n < lim);
  endtask
  // Stop first, then clear, so no stale flag leaks into the next test
  task automatic stop;
    bus(1'b1, `SDC_OFF_CTRL, 16'h0000);
    bus(1'b1, `SDC_OFF_STATUS, 16'h0001);
  endtask

  // ====================================================
  // Scenarios
  task automatic t_reset;
    bus(1'b0, `SDC_OFF_CTRL, 16'h0000);
    check(rd, 32'h0000_0000);
    bus(1'b0, 4'hc, 16'h0000);
    check(rd, 32'h0000_0000);
    check(channel_powered_down, 1'b1);
  endtask
  // Follower copies master start edges; master ends its own single shot
  task automatic t_group;
    bus(1'b1, `SDC_OFF_CTRL, 16'h0d84);
    master_start <= 1'b1;
    repeat (2) @(negedge core_clk);
    check(start_conversion_out, 1'b1);
    wait_flag(200);
    check(result_ready_flag, 1'b1);
    @(posedge core_clk);
    master_start <= 1'b0;
    repeat (2) @(negedge core_clk);
    check(start_conversion_out, 1'b0);
    check(channel_powered_down, 1'b1);
    bus(1'b0, `SDC_OFF_RESULT, 16'h0000);
    prev_grp <= 1'b1;
    bus(1'b1, `SDC_OFF_CTRL, 16'h0d83);
    wait_flag(200);
    repeat (3) @(negedge core_clk);
    bus(1'b0, `SDC_OFF_CTRL, 16'h0000);
    check(rd[`SDC_C_START], 1'b0);
    prev_grp <= 1'b0;
    stop();
  endtask
  task automatic t_formats;
    logic [15:0] fmt [3] = '{16'h0000, 16'h0010, 16'h0008};
    logic [1:0]  lv [3] = '{2'h1, 2'h2, 2'h0};
    logic [15:0] exp [9] = '{16'hfffe, 16'h7ffe, 16'hfffc, 16'h8000,
      16'h0000, 16'h0000, 16'h0000, 16'h8000, 16'h0000};
    for (int i = 0; i < 9; i++)
    begin
      level_sel <= lv[i / 3];
      bus(1'b1, `SDC_OFF_CTRL, 16'h0181 | fmt[i % 3]);
      wait_flag(400);
      bus(1'b0, `SDC_OFF_RESULT, 16'h0000);
      check(rd, {16'h0000, exp[i]});
      stop();
    end
  endtask
  task automatic t_views;
    level_sel <= 2'h1;
    bus(1'b1, `SDC_OFF_CTRL, 16'h01c1);
    wait_flag(400);
    bus(1'b0, `SDC_OFF_RESULT, 16'h0000);
    check(rd, 32'h0000_fffe);
    bus(1'b0, `SDC_OFF_RESULT, 16'h0000);
    check(rd, 32'h0000_7fff);
    bus(1'b0, `SDC_OFF_RESULT, 16'h0000);
    bus(1'b0, `SDC_OFF_CTRL, 16'h0000);
    check(rd[`SDC_C_LOW_WORD_ACCESS_ALIAS], 1'b1);
    bus(1'b1, `SDC_OFF_CTRL, 16'h00a1);
    bus(1'b0, `SDC_OFF_RESULT, 16'h0000);
    bus(1'b0, `SDC_OFF_RESULT, 16'h0000);
    check(rd, 32'h0000_7fff);
    avs_byteenable <= 4'h1;
    bus(1'b0, `SDC_OFF_RESULT, 16'h0000);
    check(rd, 32'h0000_00ff);
    avs_byteenable <= 4'hf;
    stop();
  endtask
  task automatic t_timing;
    logic [15:0] cfg [7] = '{16'h0c01, 16'h0c81, 16'h0d01, 16'h0d81,
      16'h0e01, 16'h1d81, 16'h2d81};
    int per [7] = '{256, 128, 64, 32, 512, 64, 64};
    bus(1'b1, `SDC_OFF_CTRL, 16'h0181);
    wait_flag(400);
    check(n > 96 && n < 137, 1'b1);
    stop();
    for (int i = 0; i < 7; i++)
    begin
      bus(1'b1, `SDC_OFF_CTRL, cfg[i]);
      wait_flag(600);
      check(n <= per[i] + 8, 1'b1);
      bus(1'b1, `SDC_OFF_STATUS, 16'h0001);
      @(negedge core_clk);
      check(result_ready_flag, 1'b0);
      wait_flag(600);
      check((t_last - t_prev) / 100, per[i]);
      stop();
    end
  endtask
  task automatic t_single;
    bus(1'b1, `SDC_OFF_CTRL, 16'h0d83);
    wait_flag(200);
    check(result_ready_flag, 1'b1);
    repeat (3) @(negedge core_clk);
    bus(1'b0, `SDC_OFF_CTRL, 16'h0000);
    check(rd[`SDC_C_START], 1'b0);
    check(channel_powered_down, 1'b1);
    bus(1'b0, `SDC_OFF_RESULT, 16'h0000);
    wait_flag(200);
    check(n, 200);
  endtask
  task automatic t_stop;
    bus(1'b1, `SDC_OFF_CTRL, 16'h0d81);
    wait_flag(200);
    bus(1'b0, `SDC_OFF_RESULT, 16'h0000);
    @(negedge core_clk);
    check(result_ready_flag, 1'b0);
    wait_flag(60);
    check(n <= 34, 1'b1);
    bus(1'b0, `SDC_OFF_CTRL, 16'h0000);
    check(rd[`SDC_C_START], 1'b1);
    bus(1'b1, `SDC_OFF_CTRL, 16'h0000);
    repeat (3) @(negedge core_clk);
    check(channel_powered_down, 1'b1);
    bus(1'b0, `SDC_OFF_RESULT, 16'h0000);
    wait_flag(300);
    check(n, 300);
  endtask

  // ====================================================
  // Main sequence and watchdog
  initial
  begin
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_formats();
    t_views();
    t_timing();
    t_single();
    t_stop();
    t_group();
    give_verdict();
  end
  initial
  begin
    #8_000_000;
    errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
